// ---- hdl/serial_flash_instruction_front_end.sv ----
// Serial instruction front end of a 4 Mbit serial flash
// Overview of operation
// - Opcode, address and data move in 8-bit bus cycles of eight clock periods, except the dual cycles below.
// - A new instruction starts only on a falling edge of select.
// - Inputs sampled on rising serial clock, most significant bit first.
// - Select rising inside an unfinished bus cycle abandons the instruction, except in page program data, where only the partial byte is dropped.
// - Read 03H takes three address bytes, no dummy, then streams data.
// - Streaming address increments per byte and wraps from 7FFFFH to zero.
// - Read output continues through addresses until select goes high.
// - Fast read 0BH takes three address bytes and one dummy byte.
// - Dual operation bus cycles last four clock periods, for 3BH and BBH.
// - Sector erase 20H or D7H with address; bits 18 to 12 select.
// - Block erase D8H with address; bits 18 to 16 select the block.
// - Chip erase 60H or C7H stands alone without further cycles.
// - Page program 02H, three address bytes, then 1 to 256 bytes.
// - Status read 05H repeats the status byte until select rises.
// - ABH plus 24 address bits streams the identifier until select rises.
// - ABH alone leaves sleep; trailing address bits mean identifier read.
// - B9H alone enters deep sleep.
// - Address bits above the array width are ignored.
// - Write enable latch clears at reset and after each write instruction executed while not busy.
// - Dual output puts odd bits on the high line, even on low.
`timescale 1ns/1ps
`default_nettype none

module serial_flash_instruction_front_end
   import sfie_pkg::*;
#(
   parameter logic [7:0]  IDENT_CODE = 8'h5A,         // Arbitrary value
   parameter logic [31:0] JEDEC_CODE = 32'hA5C3_3C5A  // Arbitrary value
) (
   input  wire logic              clk_i,                   // System clock, 10 MHz
   input  wire logic              rst_i,                   // Synchronous reset, high
   input  wire logic              sck_i,                   // Serial clock pin
   input  wire logic              cs_n_i,                  // Select pin, low active
   input  wire logic              serial_line_low_i,       // Low line, input side
   output logic                   serial_line_low_o,       // Low line, output value
   output logic                   serial_line_low_oe_n_o,  // Low line, drive when low
   input  wire logic              serial_line_high_i,      // High line, input side
   output logic                   serial_line_high_o,      // High line, output value
   output logic                   serial_line_high_oe_n_o, // High line, drive when low
   output logic [ADDR_W-1:0]      mem_addr_o,              // Array read address
   input  wire logic [7:0]        mem_data_i,              // Array data, one cycle late
   input  wire logic              busy_i,                  // Back end busy flag
   input  wire logic [5:0]        status_i,                // Status bits 7 to 2
   output wr_evt_t                evt_o,                   // Write event pulse
   output logic                   wel_o,                   // Write enable latch
   output logic                   sleep_o                  // Deep sleep state
);

   // Synchronisers and edge history
   logic [2:0]        sck_sync_q;
   logic [2:0]        cs_sync_q;
   logic [1:0]        lo_sync_q;
   logic [1:0]        hi_sync_q;
   // Protocol state
   state_t            state_q;
   logic [2:0]        cnt_q;
   logic [7:0]        sh_q;
   logic [7:0]        opc_q;
   logic [23:0]       addr_q;
   logic [1:0]        hdr_q;
   logic              dummy_q;
   logic              dual_in_q;
   logic              dual_out_q;
   out_src_t          src_q;
   logic [ADDR_W-1:0] mem_addr_q;
   logic [ADDR_W-1:0] prog_addr_q;
   logic              prog_any_q;
   logic [7:0]        wdata_q;
   logic [7:0]        out_q;
   logic [2:0]        ocnt_q;
   logic [1:0]        id_idx_q;
   logic              lo_o_q;
   logic              lo_oe_n_q;
   logic              hi_o_q;
   logic              hi_oe_n_q;
   // Results
   wr_evt_t           evt_q;
   logic              wel_q;
   logic              sleep_q;
   // Combinational
   logic              sck_rise;
   logic              sck_fall;
   logic              cs_fall;
   logic              cs_rise;
   logic              in_done;
   logic [7:0]        in_byte;
   logic [7:0]        cur_byte;
   logic [7:0]        status_byte;
   logic              prog_byte_now;
   logic              allowed;
   wr_op_t            exec_op;

   // Operations that need the write enable latch
   function automatic logic needs_wel(input wr_op_t op);
      needs_wel = (op == WOP_PROG_BYTE) || (op == WOP_PROG_COMMIT) || (op == WOP_SECTOR) ||
                  (op == WOP_BLOCK) || (op == WOP_CHIP) || (op == WOP_STATUS);
   endfunction : needs_wel

   // Address carried with a finished operation
   function automatic logic [ADDR_W-1:0] evt_addr(input wr_op_t op, input logic [23:0] a);
      case (op)
         WOP_SECTOR:      evt_addr = {a[ADDR_W-1:SECTOR_LSB], 12'h000};
         WOP_BLOCK:       evt_addr = {a[ADDR_W-1:BLOCK_LSB], 16'h0000};
         WOP_PROG_COMMIT: evt_addr = a[ADDR_W-1:0];
         default:         evt_addr = '0;
      endcase
   endfunction : evt_addr

   // Two-stage sync of every pin, third stage only for edges
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_sync_q <= 3'h0;
         cs_sync_q  <= 3'h7;
         lo_sync_q  <= 2'h0;
         hi_sync_q  <= 2'h0;
      end else begin
         sck_sync_q <= {sck_sync_q[1:0], sck_i};
         cs_sync_q  <= {cs_sync_q[1:0], cs_n_i};
         lo_sync_q  <= {lo_sync_q[0], serial_line_low_i};
         hi_sync_q  <= {hi_sync_q[0], serial_line_high_i};
      end
   end

   // Edges and incoming byte assembly
   assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
   assign sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
   assign cs_fall  = ~cs_sync_q[1] & cs_sync_q[2];
   assign cs_rise  = cs_sync_q[1] & ~cs_sync_q[2];
   assign in_done  = sck_rise && (cnt_q == (dual_in_q ? DUAL_LAST : SINGLE_LAST));
   assign in_byte  = dual_in_q ? {sh_q[5:0], hi_sync_q[1], lo_sync_q[1]}
                               : {sh_q[6:0], lo_sync_q[1]};
   assign allowed  = wel_q && !busy_i;
   assign prog_byte_now = in_done && !cs_sync_q[1] && state_q == ST_DATA_IN &&
                          opc_q == PROGRAM_CMD;

   // Status byte with live busy and latch bits
   always_comb begin
      status_byte              = {status_i, 2'b00};
      status_byte[ST_BUSY_BIT] = busy_i;
      status_byte[ST_WEL_BIT]  = wel_q;
   end

   // Next byte to stream out
   always_comb begin
      case (src_q)
         SRC_STATUS: cur_byte = status_byte;
         SRC_IDENT:  cur_byte = IDENT_CODE;
         SRC_JEDEC: begin
            case (id_idx_q)
               2'h0:    cur_byte = JEDEC_CODE[31:24];
               2'h1:    cur_byte = JEDEC_CODE[23:16];
               2'h2:    cur_byte = JEDEC_CODE[15:8];
               default: cur_byte = JEDEC_CODE[7:0];
            endcase
         end
         default:    cur_byte = mem_data_i;
      endcase
   end

   // Instruction sequencer, shifter and output pins
   always_ff @(posedge clk_i) begin
      if (rst_i || cs_sync_q[1]) begin
         state_q    <= ST_IDLE;
         cnt_q      <= 3'h0;
         hdr_q      <= 2'h0;
         dummy_q    <= 1'b0;
         dual_in_q  <= 1'b0;
         dual_out_q <= 1'b0;
         prog_any_q <= 1'b0;
         ocnt_q     <= 3'h0;
         id_idx_q   <= 2'h0;
         lo_oe_n_q  <= 1'b1;
         hi_oe_n_q  <= 1'b1;
         if (rst_i) begin
            sh_q        <= 8'h00;
            opc_q       <= 8'h00;
            addr_q      <= 24'h000000;
            src_q       <= SRC_MEM;
            mem_addr_q  <= '0;
            prog_addr_q <= '0;
            wdata_q     <= 8'h00;
            out_q       <= 8'h00;
            lo_o_q      <= 1'b0;
            hi_o_q      <= 1'b0;
         end
      end else if (state_q == ST_IDLE) begin
         if (cs_fall) begin
            state_q <= ST_OPCODE;
         end
      end else if (sck_rise && state_q == ST_WAIT_END) begin
         state_q <= ST_IGNORE;
      end else if (sck_rise && state_q != ST_DATA_OUT && state_q != ST_IGNORE) begin
         sh_q  <= in_byte;
         cnt_q <= in_done ? 3'h0 : cnt_q + 3'h1;
         if (in_done) begin
            case (state_q)
               ST_OPCODE: begin
                  opc_q <= in_byte;
                  src_q <= SRC_MEM;
                  if (sleep_q && in_byte != IDENT_READ_CMD) begin
                     state_q <= ST_IGNORE;
                  end else begin
                     case (in_byte)
                        READ_CMD, SECTOR_A_CMD, SECTOR_B_CMD, BLOCK_CMD, PROGRAM_CMD: begin
                           state_q <= ST_ADDR;
                        end
                        FAST_READ_CMD: begin
                           state_q <= ST_ADDR;
                           dummy_q <= 1'b1;
                        end
                        DUAL_OUT_CMD: begin
                           state_q    <= ST_ADDR;
                           dummy_q    <= 1'b1;
                           dual_out_q <= 1'b1;
                        end
                        DUAL_IO_CMD: begin
                           state_q    <= ST_ADDR;
                           dummy_q    <= 1'b1;
                           dual_out_q <= 1'b1;
                           dual_in_q  <= 1'b1;
                        end
                        IDENT_READ_CMD: begin
                           state_q <= ST_ADDR;
                           src_q   <= SRC_IDENT;
                        end
                        CHIP_A_CMD, CHIP_B_CMD, WRITE_ENABLE_CMD, WRITE_DISABLE_CMD,
                        SLEEP_ENTRY_CMD: begin
                           state_q <= ST_WAIT_END;
                        end
                        STATUS_READ_CMD: begin
                           state_q <= ST_DATA_OUT;
                           src_q   <= SRC_STATUS;
                        end
                        STATUS_WRITE_CMD: begin
                           state_q <= ST_DATA_IN;
                        end
                        JEDEC_READ_CMD: begin
                           state_q <= ST_DATA_OUT;
                           src_q   <= SRC_JEDEC;
                        end
                        default: begin
                           state_q <= ST_IGNORE;
                        end
                     endcase
                  end
               end
               ST_ADDR: begin
                  addr_q <= {addr_q[15:0], in_byte};
                  hdr_q  <= hdr_q + 2'h1;
                  if (hdr_q == ADDR_LAST_IDX) begin
                     mem_addr_q  <= {addr_q[10:0], in_byte};
                     prog_addr_q <= {addr_q[10:0], in_byte};
                     case (opc_q)
                        SECTOR_A_CMD, SECTOR_B_CMD, BLOCK_CMD: state_q <= ST_WAIT_END;
                        PROGRAM_CMD:    state_q <= ST_DATA_IN;
                        IDENT_READ_CMD: state_q <= ST_DATA_OUT;
                        default:        state_q <= dummy_q ? ST_DUMMY : ST_DATA_OUT;
                     endcase
                  end
               end
               ST_DUMMY: begin
                  state_q   <= ST_DATA_OUT;
                  dual_in_q <= 1'b0;
               end
               ST_DATA_IN: begin
                  if (opc_q == STATUS_WRITE_CMD) begin
                     wdata_q <= in_byte;
                     state_q <= ST_WAIT_END;
                  end else begin
                     prog_addr_q[7:0] <= prog_addr_q[7:0] + 8'h01;  // Wraps inside the page
                     prog_any_q       <= 1'b1;
                  end
               end
               default: begin
                  state_q <= ST_IGNORE;
               end
            endcase
         end
      end else if (sck_fall && state_q == ST_DATA_OUT) begin
         if (ocnt_q == 3'h0) begin
            hi_o_q     <= cur_byte[7];
            hi_oe_n_q  <= 1'b0;
            lo_o_q     <= dual_out_q ? cur_byte[6] : lo_o_q;
            lo_oe_n_q  <= ~dual_out_q;
            out_q      <= dual_out_q ? {cur_byte[5:0], 2'b00} : {cur_byte[6:0], 1'b0};
            ocnt_q     <= dual_out_q ? DUAL_LAST : SINGLE_LAST;
            mem_addr_q <= mem_addr_q + 19'h00001;
            id_idx_q   <= id_idx_q + 2'h1;
         end else begin
            hi_o_q <= out_q[7];
            lo_o_q <= dual_out_q ? out_q[6] : lo_o_q;
            out_q  <= dual_out_q ? {out_q[5:0], 2'b00} : {out_q[6:0], 1'b0};
            ocnt_q <= ocnt_q - 3'h1;
         end
      end
   end

   // Operation finished by a select rise on a whole bus cycle, or anywhere in page program data
   always_comb begin
      exec_op = WOP_NONE;
      if (cs_rise) begin
         case (state_q)
            ST_WAIT_END: begin
               case (opc_q)
                  SECTOR_A_CMD, SECTOR_B_CMD: exec_op = WOP_SECTOR;
                  BLOCK_CMD:                  exec_op = WOP_BLOCK;
                  CHIP_A_CMD, CHIP_B_CMD:     exec_op = WOP_CHIP;
                  STATUS_WRITE_CMD:           exec_op = WOP_STATUS;
                  WRITE_ENABLE_CMD:           exec_op = WOP_WEN;
                  WRITE_DISABLE_CMD:          exec_op = WOP_WDIS;
                  SLEEP_ENTRY_CMD:            exec_op = WOP_SLEEP;
                  default:                    exec_op = WOP_NONE;
               endcase
            end
            ST_DATA_IN: begin
               if (opc_q == PROGRAM_CMD && prog_any_q) begin
                  exec_op = WOP_PROG_COMMIT;  // Partial byte dropped
               end
            end
            ST_ADDR: begin
               if (opc_q == IDENT_READ_CMD && hdr_q == 2'h0 && cnt_q == 3'h0) begin
                  exec_op = WOP_WAKE;
               end
            end
            default: exec_op = WOP_NONE;
         endcase
      end
   end

   // Write events toward the array back end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_q <= '0;
      end else if (prog_byte_now && allowed) begin
         evt_q <= {1'b1, WOP_PROG_BYTE, prog_addr_q, in_byte};
      end else if (needs_wel(exec_op) && allowed) begin
         evt_q <= {1'b1, exec_op, evt_addr(exec_op, addr_q), wdata_q};
      end else begin
         evt_q <= '0;
      end
   end

   // Write enable latch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wel_q <= 1'b0;
      end else if (exec_op == WOP_WEN) begin
         wel_q <= 1'b1;
      end else if (exec_op == WOP_WDIS || (needs_wel(exec_op) && allowed)) begin
         wel_q <= 1'b0;
      end
   end

   // Deep sleep state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sleep_q <= 1'b0;
      end else if (exec_op == WOP_SLEEP) begin
         sleep_q <= 1'b1;
      end else if (exec_op == WOP_WAKE) begin
         sleep_q <= 1'b0;
      end
   end

   // Outputs straight from flops
   assign serial_line_low_o       = lo_o_q;
   assign serial_line_low_oe_n_o  = lo_oe_n_q;
   assign serial_line_high_o      = hi_o_q;
   assign serial_line_high_oe_n_o = hi_oe_n_q;
   assign mem_addr_o              = mem_addr_q;
   assign evt_o                   = evt_q;
   assign wel_o                   = wel_q;
   assign sleep_o                 = sleep_q;

   // Checks on the sequencer
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_last_addr(logic [7:0] op);
      state_q == ST_ADDR && hdr_q == ADDR_LAST_IDX && in_done && !cs_sync_q[1] && opc_q == op;
   endsequence

   sequence s_byte_load;
      sck_fall && state_q == ST_DATA_OUT && ocnt_q == 3'h0 && !cs_sync_q[1];
   endsequence

   a_start_on_fall: assert property (state_q == ST_IDLE && !cs_fall |=> state_q == ST_IDLE)
      else $error("instruction started without a select fall");
   a_abort_on_select: assert property (cs_sync_q[1] |=> state_q == ST_IDLE && hi_oe_n_q)
      else $error("select high did not return to standby");
   a_read_no_dummy: assert property (s_last_addr(READ_CMD) |=> state_q == ST_DATA_OUT)
      else $error("normal read did not start data after address");
   a_fast_dummy: assert property (s_last_addr(FAST_READ_CMD) |=> state_q == ST_DUMMY)
      else $error("fast read skipped its dummy byte");
   a_addr_wrap: assert property (s_byte_load ##0 mem_addr_q == ADDR_TOP |=> mem_addr_q == '0)
      else $error("read address did not wrap to zero");
   a_dual_drive: assert property (s_byte_load ##0 dual_out_q |=> !lo_oe_n_q && !hi_oe_n_q
                                  && hi_o_q == $past(cur_byte[7]) && lo_o_q == $past(cur_byte[6]))
      else $error("dual output bit pairing wrong");
   a_status_repeat: assert property (s_byte_load ##0 src_q == SRC_STATUS
                                     |=> hi_o_q == $past(status_byte[7]))
      else $error("status byte not repeated");
   a_unknown_ignored: assert property (state_q == ST_OPCODE && in_done && !cs_sync_q[1]
                                       && !sleep_q && in_byte == 8'hFF |=> state_q == ST_IGNORE)
      else $error("unknown opcode not ignored");
   a_wel_clears: assert property (needs_wel(exec_op) && allowed |=> !wel_q ##1 !evt_q.valid)
      else $error("write enable latch not cleared after write");
   a_sleep_entry: assert property (exec_op == WOP_SLEEP |=> sleep_q [*2])
      else $error("sleep entry not taken");

endmodule : serial_flash_instruction_front_end

`default_nettype wire

// ---- shared/sfie_pkg.sv ----
// Constants, opcodes and carrier types for the serial flash instruction front end
package sfie_pkg;

   // Array geometry
   localparam int          ADDR_W        = 19;         // 4 Mbit array, byte addressed
   localparam int          SECTOR_LSB    = 12;         // 4 KByte sector select starts here
   localparam int          BLOCK_LSB     = 16;         // 64 KByte block select starts here
   localparam int          PAGE_BYTES    = 256;        // Page program limit per page
   localparam logic [1:0]  ADDR_LAST_IDX = 2'h2;       // Third of three address bytes
   localparam logic [ADDR_W-1:0] ADDR_TOP = 19'h7FFFF; // Highest byte address

   // Bus cycle lengths in serial clock rising edges, minus one
   localparam logic [2:0]  SINGLE_LAST   = 3'h7;       // Eight periods per byte
   localparam logic [2:0]  DUAL_LAST     = 3'h3;       // Four periods per byte

   // Status byte layout
   localparam int          ST_BUSY_BIT   = 0;
   localparam int          ST_WEL_BIT    = 1;

   // Highest serial clock rates, informative only
   localparam int          READ_MAX_HZ   = 30_000_000;
   localparam int          FAST_MAX_HZ   = 40_000_000;

   // Opcodes
   localparam logic [7:0] READ_CMD          = 8'h03;
   localparam logic [7:0] FAST_READ_CMD     = 8'h0B;
   localparam logic [7:0] DUAL_OUT_CMD      = 8'h3B;
   localparam logic [7:0] DUAL_IO_CMD       = 8'hBB;
   localparam logic [7:0] SECTOR_A_CMD      = 8'h20;
   localparam logic [7:0] SECTOR_B_CMD      = 8'hD7;
   localparam logic [7:0] BLOCK_CMD         = 8'hD8;
   localparam logic [7:0] CHIP_A_CMD        = 8'h60;
   localparam logic [7:0] CHIP_B_CMD        = 8'hC7;
   localparam logic [7:0] PROGRAM_CMD       = 8'h02;
   localparam logic [7:0] STATUS_READ_CMD   = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD  = 8'h01;
   localparam logic [7:0] WRITE_ENABLE_CMD  = 8'h06;
   localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
   localparam logic [7:0] IDENT_READ_CMD    = 8'hAB;  // Also the sleep exit opcode
   localparam logic [7:0] JEDEC_READ_CMD    = 8'h9F;
   localparam logic [7:0] SLEEP_ENTRY_CMD   = 8'hB9;

   // Protocol states
   typedef enum logic [2:0] {
      ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA_IN, ST_DATA_OUT, ST_WAIT_END, ST_IGNORE
   } state_t;

   // Source of streamed output bytes
   typedef enum logic [1:0] {SRC_MEM, SRC_STATUS, SRC_IDENT, SRC_JEDEC} out_src_t;

   // Operations finished by the front end
   typedef enum logic [3:0] {
      WOP_NONE, WOP_PROG_BYTE, WOP_PROG_COMMIT, WOP_SECTOR, WOP_BLOCK, WOP_CHIP,
      WOP_STATUS, WOP_WEN, WOP_WDIS, WOP_SLEEP, WOP_WAKE
   } wr_op_t;

   // Write event handed to the array back end
   typedef struct packed {
      logic              valid;
      wr_op_t            op;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } wr_evt_t;

endpackage : sfie_pkg

// ---- tb/spi_host_model.sv ----
// SPI host model driving select, clock and low data line
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input  wire logic clk_i,  // Bench clock
   input  wire logic miso_i, // High line level
   output logic      sck_o,  // Serial clock, idle low
   output logic      cs_n_o, // Select, low active
   output logic      mosi_o  // Low line drive
);
   // Idle frame state at time zero
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // Select falls before the opcode
   task automatic start();
      @(negedge clk_i);
      cs_n_o = 1'b0;
      repeat (6) @(negedge clk_i);
   endtask : start
   // Bus cycle, MSB first, data steady around the rise
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         sck_o = 1'b0;
         mosi_o = tx[i];
         repeat (4) @(negedge clk_i);
         sck_o = 1'b1;
         repeat (4) @(negedge clk_i);
         rx[i] = miso_i;
      end
   endtask : xfer
   // Clock parks low, released line toggles, select rises
   task automatic stop();
      sck_o = 1'b0;
      mosi_o = ~mosi_o;
      repeat (4) @(negedge clk_i);
      cs_n_o = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask : stop
endmodule : spi_host_model
`default_nettype wire

// ---- tb/test_serial_flash_instruction_front_end.sv ----
// Self-checking bench for the serial flash instruction front end
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_instruction_front_end;
   import sfie_pkg::*;
   localparam logic [7:0]  IDENT = 8'h5A;         // Arbitrary value
   localparam logic [31:0] JEDEC = 32'hA5C3_3C5A; // Arbitrary value
   localparam logic [5:0]  STAT  = 6'h2D;
   logic              clk_i, rst_i, sck, cs_n, mosi, lo_o, lo_oe_n, hi_o, hi_oe_n, write_enable_latch, sleep;
   logic [ADDR_W-1:0] maddr;
   logic [7:0]        rx;
   logic [7:0]        mdata = 8'h00;
   wr_evt_t           evt, last_evt;
   int                failures, checked;
   wire logic         hi_w, lo_w;
   // Undriven lines show a changing pattern
   assign hi_w = hi_oe_n ? ~mosi : hi_o;
   assign lo_w = lo_oe_n ? mosi : lo_o;
   // Array contents follow the address, one clock late
   always @(posedge clk_i) mdata <= maddr[7:0] ^ 8'h3C;
   always @(posedge clk_i) if (evt.valid === 1'b1) last_evt <= evt;
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   spi_host_model HOST (.clk_i(clk_i), .miso_i(hi_w), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
   serial_flash_instruction_front_end #(.IDENT_CODE(IDENT), .JEDEC_CODE(JEDEC)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .serial_line_low_i(lo_w),
      .serial_line_low_o(lo_o), .serial_line_low_oe_n_o(lo_oe_n), .serial_line_high_i(hi_w),
      .serial_line_high_o(hi_o), .serial_line_high_oe_n_o(hi_oe_n), .mem_addr_o(maddr),
      .mem_data_i(mdata), .busy_i(1'b0), .status_i(STAT), .evt_o(evt), .wel_o(write_enable_latch),
      .sleep_o(sleep));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic end_of_test();
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   // Opcode then address bytes in one frame
   task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int nab);
      HOST.start();
      HOST.xfer(op, 8, rx);
      for (int i = 0; i < nab; i++)
         HOST.xfer(8'({a, 8'h00} >> (24 - 8*i)), 8, rx);  // Fourth byte is a zero dummy
   endtask : hdr
   task automatic t_abort();
      HOST.start();
      HOST.xfer(WRITE_ENABLE_CMD, 7, rx);
      HOST.stop();
      chk("wel", 0, write_enable_latch);
      hdr(WRITE_ENABLE_CMD, 0, 0);
      HOST.stop();
      hdr(8'hFF, 24'h123456, 2);
      HOST.stop();
      chk("wel", 1, write_enable_latch);
   endtask : t_abort
   task automatic t_reads();
      hdr(READ_CMD, 24'hF7FFFE, 3);
      for (int i = 0; i < 3; i++) begin
         HOST.xfer(8'h00, 8, rx);
         chk("read", {24'h0, 8'hFE + 8'(i)} ^ 32'h3C, rx);
      end
      chk("maddr", 19'h00001, maddr);
      HOST.stop();
      hdr(FAST_READ_CMD, 24'h012345, 4);
      HOST.xfer(8'h00, 8, rx);
      chk("fast", 8'h79, rx);
      HOST.stop();
      hdr(STATUS_READ_CMD, 0, 0);
      repeat (2) begin
         HOST.xfer(8'h00, 8, rx);
         chk("status", {STAT, 2'b10}, rx);
      end
      HOST.stop();
   endtask : t_reads
   // Dual reads: odd bits on the high line, even bits on the low line
   task automatic t_dual();
      logic [7:0] e;
      hdr(DUAL_OUT_CMD, 24'h012345, 4);
      for (int i = 0; i < 2; i++) begin
         e = (8'h45 + 8'(i)) ^ 8'h3C;
         HOST.xfer(8'h00, 4, rx);
         chk("dual odd", {e[7], e[5], e[3], e[1]}, rx[7:4]);
         chk("dual even", {1'b0, e[0]}, {lo_oe_n, lo_o});
      end
      HOST.stop();
      hdr(DUAL_IO_CMD, 0, 0);
      repeat (4) HOST.xfer(8'hF0, 4, rx); // Address 555555h, then dummy
      HOST.xfer(8'h00, 4, rx);
      e = 8'h55 ^ 8'h3C;
      chk("dual io", {e[7], e[5], e[3], e[1]}, rx[7:4]);
      chk("dual addr", 19'h55556, maddr);
      HOST.stop();
   endtask : t_dual
   task automatic t_writes();
      logic [7:0]  ops [7] = '{SECTOR_A_CMD, SECTOR_B_CMD, BLOCK_CMD, CHIP_A_CMD, CHIP_B_CMD,
                               PROGRAM_CMD, STATUS_WRITE_CMD};
      wr_op_t      exp [7] = '{WOP_SECTOR, WOP_SECTOR, WOP_BLOCK, WOP_CHIP, WOP_CHIP,
                               WOP_PROG_COMMIT, WOP_STATUS};
      logic [18:0] ea [7] = '{19'h35000, 19'h35000, 19'h30000, 19'h0, 19'h0, 19'h35678, 19'h0};
      for (int i = 0; i < 7; i++) begin
         last_evt = '0;
         hdr(WRITE_ENABLE_CMD, 0, 0);
         HOST.stop();
         hdr(ops[i], 24'h335678, (i == 3 || i == 4 || i == 6) ? 0 : 3);
         if (i >= 5)
            HOST.xfer(8'hA5, 8, rx);
         HOST.stop();
         chk("op", 32'(exp[i]), 32'(last_evt.op));
         if (i != 3 && i != 4 && i != 6)
            chk("addr", ea[i], last_evt.addr);
         if (i == 6)
            chk("data", 8'hA5, last_evt.data);
         chk("wel", 0, write_enable_latch);
      end
      hdr(WRITE_ENABLE_CMD, 0, 0);
      HOST.stop();
      chk("wel", 1, write_enable_latch);
      hdr(WRITE_DISABLE_CMD, 0, 0);
      HOST.stop();
      chk("wel", 0, write_enable_latch);
   endtask : t_writes
   task automatic t_ids();
      hdr(SLEEP_ENTRY_CMD, 0, 0);
      HOST.stop();
      chk("sleep", 1, sleep);
      hdr(IDENT_READ_CMD, 0, 0);
      HOST.stop();
      chk("sleep", 0, sleep);
      hdr(IDENT_READ_CMD, 24'h0, 3);
      repeat (2) begin
         HOST.xfer(8'h00, 8, rx);
         chk("ident", IDENT, rx);
      end
      HOST.stop();
      hdr(JEDEC_READ_CMD, 0, 0);
      for (int i = 0; i < 5; i++) begin
         HOST.xfer(8'h00, 8, rx);
         chk("jedec", JEDEC[31-8*(i%4) -: 8], rx);
      end
      HOST.stop();
   endtask : t_ids
   // Watchdog against a hung run
   initial begin
      repeat (60000) @(posedge clk_i);
      failures++;
      end_of_test();
   end
   initial begin
      rst_i = 1'b1;
      failures = 0;
      checked = 0;
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      t_abort();
      t_reads();
      t_dual();
      t_writes();
      t_ids();
      end_of_test();
   end
endmodule : test_serial_flash_instruction_front_end
`default_nettype wire
